// *** include/spd_pkg.sv ***
// Purpose: constants and types for the servo panel alarm and io display
// Assumes: one 10 MHz clock, apb register access
// Notes: control modes, pin functions and register map live here
package spd_pkg;
  localparam int CLK_NS = 100;
  localparam int BLINK_MS = 250; // dp flicker half period
  localparam int BLINK_CYC = BLINK_MS * 1000000 / CLK_NS;
  localparam int HIST_N = 16;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EVT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] OFS_FORCE = 8'h10;
  localparam logic [7:0] OFS_ASSIGN = 8'h14;
  localparam logic [7:0] OFS_ALARM = 8'h18;
  localparam logic [7:0] OFS_PINS = 8'h1c;
  // field positions
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_HCLR_BIT = 1;
  localparam int EVT_NEW = 0;
  localparam int EVT_CLR = 1;
  localparam int EVT_REFUSE = 2;
  localparam int MODE_ACT_LSB = 4;
  localparam int ALM_ACT_BIT = 8;
  localparam int ALM_CNT_LSB = 16;
  localparam int PINS_OUT_LSB = 8;
  localparam int PINS_SCR_LSB = 16;
  // pin order: in 15,19,41,42,43,44  out 23,24,33,48,49
  localparam int N_IN = 6;
  localparam int N_OUT = 5;
  // control modes
  localparam logic [2:0] M_P = 3'h0;
  localparam logic [2:0] M_PS = 3'h1;
  localparam logic [2:0] M_S = 3'h2;
  localparam logic [2:0] M_ST = 3'h3;
  localparam logic [2:0] M_T = 3'h4;
  localparam logic [2:0] M_TP = 3'h5;
  localparam logic [2:0] MODE_RST = M_P;
  // pin function codes, 0 = unassigned, bit index = code - 1
  localparam logic [3:0] F_NONE = 4'h0;
  localparam logic [3:0] F_SON = 4'h1;
  localparam logic [3:0] F_RES = 4'h2;
  localparam logic [3:0] F_ST1 = 4'h3;
  localparam logic [3:0] F_ST2 = 4'h4;
  localparam logic [3:0] F_RS1 = 4'h5;
  localparam logic [3:0] F_RS2 = 4'h6;
  localparam logic [3:0] F_CLR = 4'h7;
  localparam logic [3:0] F_STOP = 4'h8;
  localparam logic [3:0] F_LSP = 4'h9;
  localparam logic [3:0] F_LSN = 4'ha;
  localparam logic [3:0] F_MAX = F_LSN;
  typedef enum logic [3:0] {
    SCR_STATUS = 4'h1, SCR_DIAG = 4'h2, SCR_ALARM = 4'h4, SCR_PARAM = 4'h8
  } spd_screen_type;
  typedef struct packed {
    logic reverse_limit_in;
    logic forward_limit_in;
    logic forced_stop_in;
    logic droop_clear_in;
    logic reverse_dir_select_in;
    logic forward_dir_select_in;
    logic reverse_start_in;
    logic forward_start_in;
    logic fault_reset_in;
    logic servo_enable_in;
  } spd_func_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } spd_apb_rsp_type;
endpackage

// *** rtl/spd_panel.sv ***
// Purpose: panel supervision: alarm display and clear, history, parameter
//   stepping, io display on seven segments, pin mapping, forced outputs
// Assumes: keys, pins and core status are synchronous to clk_i
// Notes: single clock, state held in one struct, apb slave with no waits
`timescale 1ns/1ps
// Functional notes
// (R1) new alarm forces current alarm screen
// (R2) keys navigate during alarm, digit4 dp flickers
// (R3) cleared alarm: reset, set key, fault_reset
// (R4) history erased only by clear parameter; the nrst_i reset also clears it
// (R5) up/down steps alarm history entries
// (R6) up/down steps parameter number in group
// (R7) new operation mode acts after power cycle
// (R8) diag segment lit when pin on
// (R9) six control modes including switching ones
// (R10) pin function chosen by control mode
// (R11) pins strictly inputs or outputs
// (R12) torque mode leaves limits, pin24 unassigned
// (R13) io assign parameters override default mapping
// (R14) mode key reaches diagnostic screen
// (R15) forced outputs replace all status outputs while forcing is on
// (R16) forced output only while servo enable off
// (R17) two low digits show alarm number
module spd_panel
  import spd_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic key_mode_i,
  input wire logic key_up_i,
  input wire logic key_down_i,
  input wire logic key_set_i,
  input wire logic alarm_cause_i,
  input wire logic [7:0] alarm_code_i,
  input wire logic [2:0] op_mode_nv_i,
  input wire logic sub_select_i,
  input wire logic [N_IN-1:0] pin_in_i,
  input wire logic core_ready_i,
  input wire logic core_zero_speed_i,
  input wire logic core_in_position_i,
  input wire logic core_speed_reached_i,
  input wire logic core_index_i,
  output logic [N_OUT-1:0] pin_out_o,
  output spd_func_type func_o,
  output logic alarm_clear_o,
  output logic [2:0] nv_mode_o,
  output logic [31:0] seg_o,
  output logic irq_o
);
  typedef struct packed {
    spd_screen_type screen;
    logic [3:0] key_prev;
    logic alm_act;
    logic [7:0] alm_code;
    logic cause_prev;
    logic [HIST_N-1:0][7:0] hist;
    logic [4:0] hist_cnt;
    logic [4:0] hist_idx;
    logic [7:0] param_idx;
    logic [2:0] mode_act;
    logic [2:0] mode_pend;
    logic started;
    logic force_en;
    logic [N_OUT-1:0] force_val;
    logic [15:0] assign_cfg;
    logic [2:0] evt;
    logic [2:0] mask;
    logic [21:0] blink_cnt;
    logic blink;
    spd_apb_rsp_type apb;
    logic irq;
    spd_func_type func;
    logic [N_OUT-1:0] pin_out;
    logic [31:0] seg;
    logic clr_pulse;
  } spd_state_type;
  localparam logic [21:0] BLINK_TOP = 22'(BLINK_CYCLES - 1);
  // hex digit to seven segments, gfedcba; entry 0 sits in the low bits
  localparam logic [15:0][6:0] SEG7 = {
    7'h71, 7'h79, 7'h5e, 7'h39, 7'h7c, 7'h77, 7'h6f, 7'h7f,
    7'h07, 7'h7d, 7'h6d, 7'h66, 7'h4f, 7'h5b, 7'h06, 7'h3f};
  spd_state_type s_q, s_d;

  // default function of a remappable pin for a base mode
  function automatic logic [3:0] dflt(input int k, input logic [2:0] m);
    logic [3:0] r;
    r = F_NONE;
    unique case (k)
      1: r = (m == M_P) ? F_RES : (m == M_S) ? F_ST1 : F_RS2;
      2: r = (m == M_P) ? F_CLR : (m == M_S) ? F_ST2 : F_RS1;
      4: r = (m == M_T) ? F_NONE : F_LSP;
      5: r = (m == M_T) ? F_NONE : F_LSN;
      default: r = F_NONE;
    endcase
    return r;
  endfunction

  // all panel behaviour in one next-state process
  always_comb begin
    logic [3:0] keys;
    logic [3:0] kr;
    logic [2:0] eff;
    logic [3:0] code;
    logic [3:0] ov;
    logic [9:0] fv;
    logic wr;
    logic rd;
    logic force_on;
    logic [N_OUT-1:0] normal;
    logic [7:0] shown;
    logic [31:0] rdat;
    logic hit;
    logic [2:0] ev_set;
    keys = '0;
    kr = '0;
    eff = M_P;
    code = F_NONE;
    ov = '0;
    fv = '0;
    wr = 1'b0;
    rd = 1'b0;
    force_on = 1'b0;
    normal = '0;
    shown = '0;
    rdat = '0;
    hit = 1'b0;
    ev_set = '0;
    s_d = s_q;
    keys = {key_set_i, key_down_i, key_up_i, key_mode_i};
    kr = keys & ~s_q.key_prev;
    s_d.key_prev = keys;
    s_d.clr_pulse = 1'b0;
    // operation mode latched once after reset release [R7]
    s_d.started = 1'b1;
    if (!s_q.started) begin
      s_d.mode_act = op_mode_nv_i;
    end
    // switching modes resolve to a base mode by submode [R9]
    unique case (s_q.mode_act)
      M_PS: eff = sub_select_i ? M_S : M_P;
      M_ST: eff = sub_select_i ? M_T : M_S;
      M_TP: eff = sub_select_i ? M_P : M_T;
      M_S: eff = M_S;
      M_T: eff = M_T;
      default: eff = M_P;
    endcase
    // pin to function mapping, override or per-mode default [R10] [R13]
    for (int k = 0; k < N_IN; k++) begin
      if (k == 0) begin
        code = F_SON;
      end else if (k == 3) begin
        code = F_STOP;
      end else begin
        ov = s_q.assign_cfg[4*(k==1 ? 0 : k==2 ? 1 : k-2) +: 4];
        code = (ov == F_NONE) ? dflt(k, eff) : ov; // [R12]
      end
      if (code != F_NONE && code <= F_MAX) begin
        fv[code - 4'h1] = fv[code - 4'h1] | pin_in_i[k]; // [R11]
      end
    end
    s_d.func = spd_func_type'(fv);
    // dp blink timebase
    if (s_q.blink_cnt == BLINK_TOP) begin
      s_d.blink_cnt = '0;
      s_d.blink = ~s_q.blink;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 22'h1;
    end
    // new alarm: latch, push history, show it [R1]
    s_d.cause_prev = alarm_cause_i;
    if (alarm_cause_i && !s_q.cause_prev && !s_q.alm_act) begin
      s_d.alm_act = 1'b1;
      s_d.alm_code = alarm_code_i;
      s_d.hist = {s_q.hist[HIST_N-2:0], alarm_code_i}; // newest first
      if (s_q.hist_cnt != 5'(HIST_N)) begin
        s_d.hist_cnt = s_q.hist_cnt + 5'h1;
      end
      s_d.screen = SCR_ALARM;
      s_d.hist_idx = '0;
      ev_set[EVT_NEW] = 1'b1;
    end else if (s_q.alm_act && !alarm_cause_i &&
                 ((kr[3] && s_q.screen == SCR_ALARM && s_q.hist_idx == '0)
                  || fv[F_RES - 4'h1])) begin
      s_d.alm_act = 1'b0; // [R3]
      s_d.clr_pulse = 1'b1;
      ev_set[EVT_CLR] = 1'b1;
    end else begin
      // screen walk by mode key, still live during an alarm [R2] [R14]
      if (kr[0]) begin
        unique case (s_q.screen)
          SCR_STATUS: s_d.screen = SCR_DIAG;
          SCR_DIAG: s_d.screen = SCR_ALARM;
          SCR_ALARM: s_d.screen = SCR_PARAM;
          SCR_PARAM: s_d.screen = SCR_STATUS;
          default: s_d.screen = SCR_STATUS;
        endcase
        s_d.hist_idx = '0;
      end else if (s_q.screen == SCR_ALARM) begin
        if (kr[1] && s_q.hist_idx != 5'(HIST_N)) begin
          s_d.hist_idx = s_q.hist_idx + 5'h1; // [R5]
        end else if (kr[2] && s_q.hist_idx != '0) begin
          s_d.hist_idx = s_q.hist_idx - 5'h1; // [R5]
        end
      end else if (s_q.screen == SCR_PARAM) begin
        if (kr[1]) begin
          s_d.param_idx = s_q.param_idx + 8'h1; // [R6]
        end else if (kr[2]) begin
          s_d.param_idx = s_q.param_idx - 8'h1; // [R6]
        end
      end
    end
    // output pins: normal status or forced while servo enable off
    normal[0] = core_zero_speed_i;
    normal[1] = (eff == M_P) ? core_in_position_i :
                (eff == M_S) ? core_speed_reached_i : 1'b0; // [R12]
    normal[2] = core_index_i;
    normal[3] = s_q.alm_act;
    normal[4] = core_ready_i;
    force_on = s_q.force_en && !pin_in_i[0]; // [R16]
    s_d.pin_out = force_on ? s_q.force_val : normal; // [R15]
    if (s_q.force_en && pin_in_i[0]) begin
      ev_set[EVT_REFUSE] = 1'b1;
    end
    // display: current alarm code or history entry in low digits [R17]
    shown = (s_q.hist_idx == '0) ? s_q.alm_code :
            (s_q.hist_idx <= s_q.hist_cnt) ?
            s_q.hist[s_q.hist_idx - 5'h1] : 8'h00;
    unique case (s_q.screen)
      SCR_DIAG: s_d.seg = {8'h00, 8'h00, 3'h0, s_q.pin_out,
                           2'h0, pin_in_i}; // [R8]
      SCR_ALARM: s_d.seg = {8'h77, 1'b0, SEG7[s_q.hist_idx[3:0]],
                            1'b0, SEG7[shown[7:4]],
                            1'b0, SEG7[shown[3:0]]}; // [R17]
      SCR_PARAM: s_d.seg = {8'h73, 8'h00, 1'b0, SEG7[s_q.param_idx[7:4]],
                            1'b0, SEG7[s_q.param_idx[3:0]]};
      default: s_d.seg = {8'h6d, 8'h00, 8'h00,
                          1'b0, SEG7[{1'b0, s_q.mode_act}]};
    endcase
    s_d.seg[31] = s_q.alm_act && s_q.blink; // [R2]
    // apb slave: answer in the first access cycle
    s_d.apb.pready = psel_i && !penable_i;
    wr = psel_i && penable_i && s_q.apb.pready && pwrite_i;
    rd = psel_i && penable_i && s_q.apb.pready && !pwrite_i;
    hit = 1'b1;
    unique case (paddr_i)
      OFS_CTRL: rdat = {31'h0, s_q.force_en};
      OFS_EVT: rdat = {29'h0, s_q.evt};
      OFS_MASK: rdat = {29'h0, s_q.mask};
      OFS_MODE: rdat = {25'h0, s_q.mode_act, 1'b0, s_q.mode_pend};
      OFS_FORCE: rdat = {27'h0, s_q.force_val};
      OFS_ASSIGN: rdat = {16'h0, s_q.assign_cfg};
      OFS_ALARM: rdat = {11'h0, s_q.hist_cnt, 7'h0, s_q.alm_act,
                         s_q.alm_code};
      OFS_PINS: rdat = {12'h0, s_q.screen, 3'h0, s_q.pin_out,
                        2'h0, pin_in_i};
      default: hit = 1'b0;
    endcase
    s_d.apb.pslverr = psel_i && !penable_i && !hit;
    s_d.apb.prdata = (psel_i && !penable_i) ? rdat : s_q.apb.prdata;
    if (wr) begin
      unique case (paddr_i)
        OFS_CTRL: begin
          s_d.force_en = pwdata_i[CTRL_FORCE_BIT];
          if (pwdata_i[CTRL_HCLR_BIT]) begin
            s_d.hist_cnt = '0; // [R4]
            s_d.hist = '0;
          end
        end
        OFS_MASK: s_d.mask = pwdata_i[2:0];
        OFS_MODE: s_d.mode_pend = pwdata_i[2:0]; // [R7]
        OFS_FORCE: s_d.force_val = pwdata_i[N_OUT-1:0];
        OFS_ASSIGN: s_d.assign_cfg = pwdata_i[15:0]; // [R13]
        default: ;
      endcase
    end
    // read clears only the bits it returned; a same-cycle event wins
    if (rd && paddr_i == OFS_EVT) begin
      s_d.evt = s_q.evt & ~s_q.apb.prdata[2:0];
    end
    s_d.evt = s_d.evt | ev_set;
    s_d.irq = |(s_d.evt & s_d.mask);
  end

  // state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.screen <= SCR_STATUS;
      s_q.mode_act <= MODE_RST;
      s_q.mode_pend <= MODE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_o = s_q.apb.prdata;
  assign pready_o = s_q.apb.pready;
  assign pslverr_o = s_q.apb.pslverr;
  assign pin_out_o = s_q.pin_out;
  assign func_o = s_q.func;
  assign alarm_clear_o = s_q.clr_pulse;
  assign nv_mode_o = s_q.mode_pend;
  assign seg_o = s_q.seg;
  assign irq_o = s_q.irq;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_alarm_shown: assert property ( // [R1]
    alarm_cause_i && !s_q.cause_prev && !s_q.alm_act
    |=> s_q.screen == SCR_ALARM && s_q.hist_idx == 5'h0 && s_q.alm_act)
    else $error("new alarm not shown");
  a_dp_flicker: assert property ( // [R2]
    s_q.alm_act && s_q.blink |=> seg_o[31])
    else $error("dp not flickering during alarm");
  a_set_clears: assert property ( // [R3]
    s_q.alm_act && !alarm_cause_i && !alarm_cause_i && key_set_i
    && !s_q.key_prev[3] && s_q.screen == SCR_ALARM && s_q.hist_idx == 5'h0
    |=> !s_q.alm_act ##0 alarm_clear_o)
    else $error("set key did not clear alarm");
  a_hist_erase: assert property ( // [R4]
    $past(s_q.hist_cnt) != 5'h0 && s_q.hist_cnt == 5'h0
    |-> $past(psel_i && penable_i && pwrite_i && paddr_i == OFS_CTRL))
    else $error("history lost without clear");
  a_hist_step: assert property ( // [R5]
    s_q.screen == SCR_ALARM && key_up_i && !s_q.key_prev[1] && !key_mode_i
    && s_q.hist_idx < 5'h10 && !(alarm_cause_i && !s_q.cause_prev)
    && !s_q.alm_act
    |=> s_q.hist_idx == $past(s_q.hist_idx) + 5'h1)
    else $error("history step missed");
  a_param_step: assert property ( // [R6]
    s_q.screen == SCR_PARAM && key_down_i && !s_q.key_prev[2]
    && !key_up_i && !key_mode_i && !alarm_cause_i && !s_q.alm_act
    |=> s_q.param_idx == $past(s_q.param_idx) - 8'h1)
    else $error("parameter step missed");
  a_mode_hold: assert property ( // [R7]
    s_q.started |=> $stable(s_q.mode_act))
    else $error("mode changed without power cycle");
  a_diag_light: assert property ( // [R8]
    s_q.screen == SCR_DIAG |=> seg_o[5:0] == $past(pin_in_i))
    else $error("io segment mismatch");
  a_torque_free: assert property ( // [R12]
    s_q.mode_act == M_T && s_q.assign_cfg == 16'h0
    && !s_q.force_en |=> !func_o.forward_limit_in && !pin_out_o[1])
    else $error("torque mode limit assigned");
  a_force_block: assert property ( // [R16]
    pin_in_i[0] |=> pin_out_o[2] == $past(core_index_i)
    && pin_out_o[3] == $past(s_q.alm_act))
    else $error("forced output while servo enabled");
  a_force_drive: assert property ( // [R15]
    s_q.force_en && !pin_in_i[0] |=> pin_out_o == $past(s_q.force_val))
    else $error("forced value not driven");
  c_alarm_clear: cover property (s_q.alm_act ##[1:50] alarm_clear_o);
  c_force: cover property (s_q.force_en && !pin_in_i[0]);
  c_diag: cover property (s_q.screen == SCR_DIAG && |pin_in_i);
endmodule

// *** verif/spd_host_model.sv ***
// Purpose: far side of the panel: operator keys, host io lines, alarm source
// Assumes: everything changes just after a rising clock edge
// Notes: the bench calls the tasks; nothing here answers by itself
`timescale 1ns/1ps
module spd_host_model
  import spd_pkg::*;
(
  input wire logic clk_i,
  output logic [3:0] keys_o, // mode, up, down, set
  output logic cause_o,
  output logic [7:0] code_o,
  output logic [N_IN-1:0] pins_o,
  output logic [4:0] core_o // ready, zero, in-pos, reached, index
);
  // quiet levels at time zero
  initial begin
    keys_o = 4'h0;
    cause_o = 1'b0;
    code_o = 8'h00;
    pins_o = '0;
    core_o = 5'h00;
  end
  // one press: a rising edge, held two cycles, then released
  task automatic press(input int k);
    @(posedge clk_i);
    keys_o[k] <= 1'b1;
    repeat (2) @(posedge clk_i);
    keys_o[k] <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // connector inputs; v is driven as given, pin15 included
  task automatic set_pins(input logic [N_IN-1:0] v);
    @(posedge clk_i);
    pins_o <= v;
  endtask
  // status lines coming from the servo core
  task automatic set_core(input logic [4:0] v);
    @(posedge clk_i);
    core_o <= v;
  endtask
  // alarm cause level and its number
  task automatic alarm(input logic on, input logic [7:0] c);
    @(posedge clk_i);
    cause_o <= on;
    code_o <= c;
  endtask
endmodule

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for the panel supervision block
// Assumes: apb slave answers with pready, blink half period shortened to 4 cycles
// Notes: mode table in rows, alarm, diag and forced output by hand
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; $display("unexpected %s expected %0h seen %0h", nm, (exp), (got)); end end
module tb_top;
  import spd_pkg::*;
  typedef struct packed {
    logic [2:0] mode;
    logic sub;
    logic [9:0] fn;
    logic p24;
  } spd_row_type;
  logic clk_i;
  logic nrst_i;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic alarm_clear;
  logic sub_sel;
  logic irq;
  logic [2:0] op_nv;
  logic [2:0] nv_mode;
  logic [3:0] keys;
  logic cause;
  logic [7:0] code;
  logic [N_IN-1:0] pins;
  logic [4:0] core;
  logic [N_OUT-1:0] pin_out;
  spd_func_type func;
  logic [31:0] seg;
  int miscompares;
  int n_compared;
  int i;
  int ones;
  int n_clr;
  // all pins high: expected functions per mode and submode
  spd_row_type rows [9] = '{
    '{M_P, 1'b0, 10'h3c3, 1'b1}, '{M_PS, 1'b0, 10'h3c3, 1'b1},
    '{M_PS, 1'b1, 10'h38d, 1'b1}, '{M_S, 1'b0, 10'h38d, 1'b1},
    '{M_ST, 1'b0, 10'h38d, 1'b1}, '{M_ST, 1'b1, 10'h0b1, 1'b0},
    '{M_T, 1'b0, 10'h0b1, 1'b0}, '{M_TP, 1'b0, 10'h0b1, 1'b0},
    '{M_TP, 1'b1, 10'h3c3, 1'b1}};
  spd_panel #(.BLINK_CYCLES(4)) spd_panel_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .key_mode_i(keys[0]), .key_up_i(keys[1]), .key_down_i(keys[2]),
    .key_set_i(keys[3]), .alarm_cause_i(cause), .alarm_code_i(code),
    .op_mode_nv_i(op_nv), .sub_select_i(sub_sel), .pin_in_i(pins),
    .core_ready_i(core[0]), .core_zero_speed_i(core[1]),
    .core_in_position_i(core[2]), .core_speed_reached_i(core[3]),
    .core_index_i(core[4]), .pin_out_o(pin_out), .func_o(func),
    .alarm_clear_o(alarm_clear), .nv_mode_o(nv_mode), .seg_o(seg),
    .irq_o(irq));
  spd_host_model spd_host_model_i (
    .clk_i(clk_i), .keys_o(keys), .cause_o(cause), .code_o(code),
    .pins_o(pins), .core_o(core));
  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // counts the one-cycle alarm clear pulses
  always @(posedge clk_i) begin
    if (alarm_clear === 1'b1) begin
      n_clr++;
    end
  end
  // verdict and end of run
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // one apb transfer; read data and error land in rd and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset for 16 cycles, outputs checked while it is held
  task automatic power_cycle();
    nrst_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    `CHK("reset outputs", 6'h00, {irq, pin_out})
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    $display("unexpected watchdog expected end seen hang");
    finish_test();
  end
  initial begin
    nrst_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    op_nv = M_P;
    sub_sel = 1'b0;
    miscompares = 0;
    n_compared = 0;
    n_clr = 0;
    // mode table: pin functions, pin24 and outputs per control mode
    for (i = 0; i < 9; i++) begin
      op_nv <= rows[i].mode;
      sub_sel <= rows[i].sub;
      power_cycle();
      spd_host_model_i.set_pins(6'h3f);
      spd_host_model_i.set_core(5'h1f);
      repeat (3) @(posedge clk_i);
      `CHK("functions", rows[i].fn, func)
      `CHK("pin24", rows[i].p24, pin_out[1])
      `CHK("outputs", 5'h15, pin_out & 5'h1d)
      apb(1'b0, OFS_MODE, 32'h0);
      `CHK("active mode", rows[i].mode, rd[6:4])
    end
    done("modes");
    op_nv <= M_P;
    sub_sel <= 1'b0;
    spd_host_model_i.set_pins(6'h00);
    spd_host_model_i.set_core(5'h00);
    power_cycle();
    apb(1'b1, OFS_MASK, 32'h7);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    apb(1'b1, OFS_ASSIGN, 32'h3);
    spd_host_model_i.set_pins(6'h02);
    repeat (3) @(posedge clk_i);
    `CHK("assigned pin19", 10'h004, func)
    apb(1'b1, OFS_ASSIGN, 32'h0);
    apb(1'b1, OFS_MODE, 32'h2);
    apb(1'b0, OFS_MODE, 32'h0);
    `CHK("pending mode", 7'h02, rd[6:0])
    `CHK("nv mode", 3'h2, nv_mode)
    done("registers");
    spd_host_model_i.press(0);
    apb(1'b0, OFS_PINS, 32'h0);
    `CHK("diag screen", 4'h2, rd[19:16])
    spd_host_model_i.set_pins(6'h2a);
    repeat (3) @(posedge clk_i);
    `CHK("diag segments", 6'h2a, seg[5:0])
    apb(1'b0, OFS_PINS, 32'h0);
    `CHK("pin readback", 6'h2a, rd[5:0])
    spd_host_model_i.set_pins(6'h00);
    done("diag");
    spd_host_model_i.alarm(1'b1, 8'h33);
    repeat (4) @(posedge clk_i);
    `CHK("alarm digit4", 7'h77, seg[30:24])
    `CHK("fault pin", 1'b1, pin_out[3])
    `CHK("irq raised", 1'b1, irq)
    apb(1'b0, OFS_PINS, 32'h0);
    `CHK("alarm screen", 4'h4, rd[19:16])
    apb(1'b0, OFS_ALARM, 32'h0);
    `CHK("alarm reg", 13'h0133, {rd[20:16], rd[7:0]})
    `CHK("alarm active", 1'b1, rd[8])
    apb(1'b0, OFS_EVT, 32'h0);
    `CHK("event new", 3'h1, rd[2:0])
    apb(1'b0, OFS_EVT, 32'h0);
    `CHK("event cleared by read", 3'h0, rd[2:0])
    repeat (2) @(posedge clk_i);
    `CHK("irq dropped", 1'b0, irq)
    spd_host_model_i.press(0);
    apb(1'b0, OFS_PINS, 32'h0);
    `CHK("param screen in alarm", 4'h8, rd[19:16])
    ones = 0;
    repeat (16) begin
      @(posedge clk_i);
      ones += int'(seg[31] === 1'b1);
    end
    `CHK("dp flicker", 1'b1, ones > 0 && ones < 16)
    done("alarm");
    spd_host_model_i.alarm(1'b0, 8'h00);
    repeat (3) spd_host_model_i.press(0);
    spd_host_model_i.press(3);
    repeat (3) @(posedge clk_i);
    apb(1'b0, OFS_ALARM, 32'h0);
    `CHK("set key clear", 1'b0, rd[8])
    `CHK("clear pulse", 1, n_clr)
    apb(1'b0, OFS_EVT, 32'h0);
    `CHK("event clear", 3'h2, rd[2:0])
    spd_host_model_i.alarm(1'b1, 8'h50);
    repeat (4) @(posedge clk_i);
    spd_host_model_i.alarm(1'b0, 8'h00);
    spd_host_model_i.set_pins(6'h02);
    repeat (4) @(posedge clk_i);
    spd_host_model_i.set_pins(6'h00);
    apb(1'b0, OFS_ALARM, 32'h0);
    `CHK("fault reset clear", 6'h04, {rd[20:16], rd[8]})
    `CHK("clear pulses", 2, n_clr)
    spd_host_model_i.press(1);
    `CHK("history 1", 24'h066d3f, seg[23:0])
    spd_host_model_i.press(1);
    `CHK("history 2", 24'h5b4f4f, seg[23:0])
    spd_host_model_i.press(2);
    `CHK("history back", 24'h066d3f, seg[23:0])
    apb(1'b1, OFS_CTRL, 32'h2);
    apb(1'b0, OFS_ALARM, 32'h0);
    `CHK("history erased", 5'h00, rd[20:16])
    spd_host_model_i.press(0);
    spd_host_model_i.press(1);
    `CHK("param up", 24'h733f06, {seg[31:24], seg[15:0]})
    repeat (2) spd_host_model_i.press(2);
    `CHK("param down", 16'h7171, seg[15:0])
    done("clear");
    apb(1'b0, OFS_EVT, 32'h0);
    apb(1'b1, OFS_FORCE, 32'h15);
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk_i);
    `CHK("forced outputs", 5'h15, pin_out)
    apb(1'b0, OFS_EVT, 32'h0);
    `CHK("no refusal", 1'b0, rd[2])
    // host breaks the servo-off condition on purpose
    spd_host_model_i.set_pins(6'h01);
    repeat (3) @(posedge clk_i);
    `CHK("force refused", 5'h00, pin_out)
    apb(1'b0, OFS_EVT, 32'h0);
    `CHK("refusal event", 1'b1, rd[2])
    spd_host_model_i.set_core(5'h05);
    repeat (2) @(posedge clk_i);
    `CHK("normal outputs a", 5'h12, pin_out)
    spd_host_model_i.set_core(5'h1a);
    repeat (2) @(posedge clk_i);
    `CHK("normal outputs b", 5'h05, pin_out)
    done("force");
    finish_test();
  end
endmodule
